// *** hdl/receive_event_history_b.sv ***
// module: sticky receive event history register b with mask, threshold counter and apb slave
`timescale 1ns/1ps
// Behaviour
// - entering a line state sets that state's history bit
// - earlier line state bits are never cleared by hardware
// - summary output high when any history bit and its mask bit are both set
// - idle bit set after two consecutive idle symbol pairs
// - threshold bit set when state counter hits zero; held until reload and clear
// - reset loads state counter with zero so threshold bit reads one
// - active bit set on a jk start delimiter pair
// - unknown bit set on unknown line state when last known was active or idle
// - outside cascade mode, event bit d4 set when any masked connection condition bit is set
// - in cascade mode d4 set if start not seen within two clock cycles (100 ns at the 50 ns clock) of ready release
// - elastic buffer fault bit set on overflow or underflow, held until cleared
// - long idle bit set after eight idle symbol pairs
// - spare bit resets to zero and steers nothing
module receive_event_history_b #(
  parameter int count_width = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // receiver events
  input wire logic [9:0] rx_pair_in,
  input wire logic rx_pair_valid_in,
  input wire logic line_unknown_in,
  input wire logic elastic_fault_in,
  input wire logic [7:0] conn_mgmt_condition_reg_in,
  input wire logic [7:0] conn_mgmt_condition_mask_in,
  input wire logic chain_ready_out_in,
  input wire logic chain_start_in,
  // summary and interrupt
  output logic rx_history_b_summary_out,
  output logic irq_out
);

  typedef enum logic [1:0] {ls_none, ls_idle, ls_active, ls_unknown} line_type;

  typedef struct packed {
    logic [7:0] history;
    logic [7:0] mask;
    logic [count_width-1:0] threshold;
    logic [count_width-1:0] counter;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic cascade_en;
    logic [3:0] idle_run;
    line_type last_known;
    logic unknown_prev;
    logic ready_prev;
    logic cascade_wait;
    logic [3:0] cascade_cnt;
    logic [31:0] rdata;
  } state_type;

  state_type s_q;
  state_type s_d;

  function automatic logic [7:0] w1_keep(input logic [7:0] cur, input logic [31:0] wd);
    w1_keep = cur & wd[7:0];
  endfunction

  logic apb_access;
  logic addr_ok;
  logic [7:0] set_ev;
  logic is_idle;
  logic is_jk;

  assign apb_access = psel_in && penable_in;
  assign addr_ok = (paddr_in == rx_history_b_pkg::history_b_offset) ||
                   (paddr_in == rx_history_b_pkg::mask_b_offset) ||
                   (paddr_in == rx_history_b_pkg::state_threshold_offset) ||
                   (paddr_in == rx_history_b_pkg::irq_status_offset) ||
                   (paddr_in == rx_history_b_pkg::irq_mask_offset) ||
                   (paddr_in == rx_history_b_pkg::control_offset);
  assign pready_out = 1'b1;
  assign pslverr_out = apb_access && !addr_ok;
  assign prdata_out = s_q.rdata;
  assign is_idle = rx_pair_valid_in && (rx_pair_in == rx_history_b_pkg::idle_pair_code);
  assign is_jk = rx_pair_valid_in && (rx_pair_in == rx_history_b_pkg::jk_pair_code);

  always_comb begin
    s_d = s_q;
    set_ev = 8'h00;
    if (rx_pair_valid_in) begin
      if (is_idle && s_q.idle_run != 4'hf) begin
        s_d.idle_run = s_q.idle_run + 4'h1;
      end else if (!is_idle) begin
        s_d.idle_run = 4'h0;
      end
    end
    // idle and long idle on reaching the pair counts
    if (is_idle && s_q.idle_run == rx_history_b_pkg::idle_pairs_min - 4'h1) begin
      set_ev[rx_history_b_pkg::idle_bit] = 1'b1;
    end
    if (is_idle && s_q.idle_run == rx_history_b_pkg::long_idle_pairs_min - 4'h1) begin
      set_ev[rx_history_b_pkg::long_idle_bit] = 1'b1;
    end
    if (s_d.idle_run >= rx_history_b_pkg::idle_pairs_min) begin
      s_d.last_known = ls_idle;
    end
    if (is_jk) begin
      set_ev[rx_history_b_pkg::active_bit] = 1'b1;
      s_d.last_known = ls_active;
    end
    s_d.unknown_prev = line_unknown_in;
    if (line_unknown_in && !s_q.unknown_prev &&
        (s_q.last_known == ls_active || s_q.last_known == ls_idle)) begin
      set_ev[rx_history_b_pkg::unknown_bit] = 1'b1;
    end
    if (line_unknown_in) begin
      s_d.last_known = ls_unknown;
    end
    // state counter runs down to zero and stops
    if (s_q.counter != '0) begin
      s_d.counter = s_q.counter - count_width'(1);
    end
    if (s_q.counter == '0) begin
      set_ev[rx_history_b_pkg::threshold_bit] = 1'b1;
    end
    if (!s_q.cascade_en && |(conn_mgmt_condition_reg_in & conn_mgmt_condition_mask_in)) begin
      set_ev[rx_history_b_pkg::conn_bit] = 1'b1;
    end
    // cascade start must follow ready release within the window
    s_d.ready_prev = chain_ready_out_in;
    if (s_q.cascade_en && s_q.ready_prev && !chain_ready_out_in) begin
      s_d.cascade_wait = 1'b1;
      s_d.cascade_cnt = 4'h0;
    end else if (s_q.cascade_wait) begin
      if (chain_start_in) begin
        s_d.cascade_wait = 1'b0;
      end else if (s_q.cascade_cnt >= 4'(rx_history_b_pkg::cascade_window_cycles)) begin
        s_d.cascade_wait = 1'b0;
        set_ev[rx_history_b_pkg::conn_bit] = 1'b1;
      end else begin
        s_d.cascade_cnt = s_q.cascade_cnt + 4'h1;
      end
    end
    if (elastic_fault_in) begin
      set_ev[rx_history_b_pkg::elastic_bit] = 1'b1;
    end
    // register writes, then hardware sets win over clears
    if (apb_access && pwrite_in) begin
      unique case (paddr_in)
        rx_history_b_pkg::history_b_offset:
          s_d.history = w1_keep(s_q.history, pwdata_in);
        rx_history_b_pkg::mask_b_offset: s_d.mask = pwdata_in[7:0];
        rx_history_b_pkg::state_threshold_offset: begin
          s_d.threshold = pwdata_in[count_width-1:0];
          s_d.counter = pwdata_in[count_width-1:0];
        end
        rx_history_b_pkg::irq_status_offset: s_d.irq_status = s_q.irq_status & ~pwdata_in[1:0];
        rx_history_b_pkg::irq_mask_offset: s_d.irq_mask = pwdata_in[1:0];
        rx_history_b_pkg::control_offset:
          s_d.cascade_en = pwdata_in[rx_history_b_pkg::cascade_en_bit];
        default: ;
      endcase
    end
    s_d.history = s_d.history | set_ev;
    s_d.history[rx_history_b_pkg::spare_pos] = s_d.history[rx_history_b_pkg::spare_pos];
    if (|set_ev[6:0]) begin
      s_d.irq_status[rx_history_b_pkg::irq_history_bit] = 1'b1;
    end
    if (elastic_fault_in) begin
      s_d.irq_status[rx_history_b_pkg::irq_elastic_bit] = 1'b1;
    end
    // read data is captured in the setup cycle so it stands at the access edge
    s_d.rdata = 32'h0;
    if (psel_in && !penable_in && !pwrite_in) begin
      unique case (paddr_in)
        rx_history_b_pkg::history_b_offset: s_d.rdata = {24'h0, s_q.history};
        rx_history_b_pkg::mask_b_offset: s_d.rdata = {24'h0, s_q.mask};
        rx_history_b_pkg::state_threshold_offset: s_d.rdata = 32'(s_q.threshold);
        rx_history_b_pkg::irq_status_offset: s_d.rdata = {30'h0, s_q.irq_status};
        rx_history_b_pkg::irq_mask_offset: s_d.rdata = {30'h0, s_q.irq_mask};
        rx_history_b_pkg::control_offset: s_d.rdata = {31'h0, s_q.cascade_en};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.history <= rx_history_b_pkg::history_reset;
      s_q.mask <= rx_history_b_pkg::mask_reset;
      s_q.last_known <= ls_none;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign rx_history_b_summary_out = |(s_q.history & s_q.mask);
  assign irq_out = |(s_q.irq_status & s_q.irq_mask);

  // checks
  a_summary_rises: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && is_jk && s_q.mask[rx_history_b_pkg::active_bit] && !(apb_access && pwrite_in)
    |=> rx_history_b_summary_out) else $error("summary not raised");
  a_spare_zero: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !s_q.history[rx_history_b_pkg::spare_pos]) else $error("spare bit set");
  a_unknown_sets: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && line_unknown_in && !s_q.unknown_prev && s_q.last_known == ls_active
    |=> s_q.history[rx_history_b_pkg::unknown_bit]) else $error("unknown not latched");
  a_active_sets: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && is_jk |=> s_q.history[2]) else $error("active not set");
  a_history_sticky: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && s_q.history[0] && !(apb_access && pwrite_in) |=> s_q.history[0])
    else $error("idle cleared by hw");
  a_zero_count: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && s_q.counter == '0 |=> s_q.history[1]) else $error("threshold not set");
  a_elastic_sets: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && elastic_fault_in |=> s_q.history[5]) else $error("fault not latched");
  a_conn_event: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && !s_q.cascade_en && |(conn_mgmt_condition_reg_in & conn_mgmt_condition_mask_in)
    |=> s_q.history[4]) else $error("conn event lost");
  // a run is watched from its first pair, so an earlier clear cannot hide it
  sequence idle_two;
    is_idle && clk_en_in && s_q.idle_run == 4'h0 ##1 is_idle && clk_en_in;
  endsequence
  sequence idle_more;
    (is_idle && clk_en_in) [*7];
  endsequence
  a_long_idle: assert property (@(posedge clock_in) disable iff (!rstn_in)
    is_idle && clk_en_in && s_q.idle_run == 4'h0 ##1 idle_more
    |=> s_q.history[rx_history_b_pkg::long_idle_bit]) else $error("long idle not set");
  sequence ready_drop;
    clk_en_in && s_q.cascade_en && s_q.ready_prev && !chain_ready_out_in;
  endsequence
  sequence no_start_two;
    clk_en_in && !chain_start_in ##1 clk_en_in && !chain_start_in;
  endsequence
  a_cascade_error: assert property (@(posedge clock_in) disable iff (!rstn_in)
    ready_drop ##1 no_start_two |=> s_q.history[rx_history_b_pkg::conn_bit])
    else $error("sync error lost");
  a_idle_pairs: assert property (@(posedge clock_in) disable iff (!rstn_in)
    idle_two |=> s_q.history[0]) else $error("idle not set");
  a_write_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && apb_access && pwrite_in && paddr_in == rx_history_b_pkg::history_b_offset &&
    !pwdata_in[2] && !is_jk |=> !s_q.history[2]) else $error("clear failed");
endmodule

// *** hdl/rx_history_b_pkg.sv ***
// package: register map, bit layout and timing for receive event history b
package rx_history_b_pkg;
  // register index as printed; the byte address is four times the index
  localparam logic [9:0] history_b_index = 10'h00a;
  localparam logic [9:0] mask_b_index = 10'h00c;
  localparam logic [11:0] history_b_offset = {history_b_index, 2'b00};
  localparam logic [11:0] mask_b_offset = {mask_b_index, 2'b00};
  localparam logic [11:0] state_threshold_offset = 12'h034;
  localparam logic [11:0] irq_status_offset = 12'h038;
  localparam logic [11:0] irq_mask_offset = 12'h03c;
  localparam logic [11:0] control_offset = 12'h040;
  localparam int idle_bit = 0;
  localparam int threshold_bit = 1;
  localparam int active_bit = 2;
  localparam int unknown_bit = 3;
  localparam int conn_bit = 4;
  localparam int elastic_bit = 5;
  localparam int long_idle_bit = 6;
  localparam int spare_pos = 7;
  localparam int cascade_en_bit = 0;
  localparam logic [7:0] history_reset = 8'h02;
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [9:0] idle_pair_code = 10'h3ff;
  localparam logic [9:0] jk_pair_code = 10'h311;
  localparam logic [3:0] idle_pairs_min = 4'h2;
  localparam logic [3:0] long_idle_pairs_min = 4'h8;
  localparam int clock_period_ns = 50;
  localparam int cascade_window_ns = 80;
  localparam int cascade_window_cycles =
    (cascade_window_ns / clock_period_ns) < 1 ? 1 : cascade_window_ns / clock_period_ns;
  localparam int irq_history_bit = 0;
  localparam int irq_elastic_bit = 1;
endpackage

// *** tb/apb_host.sv ***
// apb master model standing in for the host processor
`timescale 1ns/1ps
module apb_host (
  // clock
  input wire logic clock_in,
  // apb master side
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  int stuck = 0;
  initial begin
    psel_out = 0;
    penable_out = 0;
    pwrite_out = 0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end
  // also writes the cascade enable when the bench asks, which stops connection condition events
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int i;
    psel_out <= 1;
    penable_out <= 0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clock_in);
    penable_out <= 1;
    @(posedge clock_in);
    for (i = 0; i < 20 && pready_in !== 1'b1; i++) @(posedge clock_in);
    if (i == 20) stuck++;
    // response and read data are taken at the edge that saw pready high
    err = pslverr_in;
    q = prdata_in;
    psel_out <= 0;
    penable_out <= 0;
    // one idle edge keeps the next setup apart from this release
    @(posedge clock_in);
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the receive event history register b
`timescale 1ns/1ps
module tb_top;
  logic clock_in = 0, rstn_in = 0, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic rx_pair_valid_in = 0, line_unknown_in = 0, elastic_fault_in = 0, summary, irq, err;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, q;
  logic [9:0] rx_pair_in = 10'h000;
  logic [7:0] creg = 8'h00, cmask = 8'h00;
  logic cready = 1, cstart = 0;
  int n_errors = 0, n_tests = 0;
  typedef struct {logic [9:0] p; int n; logic u; logic e; logic [7:0] cr; logic [7:0] cm;
                  logic c; logic [7:0] x;} row_type;
  row_type rows[8] = '{'{10'h3ff, 1, 0, 0, 8'h00, 8'h00, 1, 8'h00},
    '{10'h3ff, 2, 0, 0, 8'h00, 8'h00, 1, 8'h01}, '{10'h3ff, 8, 0, 0, 8'h00, 8'h00, 1, 8'h41},
    '{10'h311, 1, 0, 0, 8'h00, 8'h00, 1, 8'h04}, '{10'h000, 0, 1, 0, 8'h00, 8'h00, 0, 8'h0c},
    '{10'h000, 0, 0, 1, 8'h00, 8'h00, 1, 8'h20}, '{10'h000, 0, 0, 0, 8'h01, 8'h02, 1, 8'h00},
    '{10'h000, 0, 0, 0, 8'h81, 8'h80, 1, 8'h10}};
  always #25 clock_in = ~clock_in;
  apb_host u_host (.clock_in(clock_in), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in),
    .prdata_in(prdata_out), .pready_in(pready_out), .pslverr_in(pslverr_out));
  receive_event_history_b u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .clk_en_in(1'b1),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .rx_pair_in(rx_pair_in), .rx_pair_valid_in(rx_pair_valid_in),
    .line_unknown_in(line_unknown_in), .elastic_fault_in(elastic_fault_in),
    .conn_mgmt_condition_reg_in(creg), .conn_mgmt_condition_mask_in(cmask),
    .chain_ready_out_in(cready), .chain_start_in(cstart),
    .rx_history_b_summary_out(summary), .irq_out(irq));
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1, a, d, q, err);
    if (u_host.stuck != 0) stop_test;
  endtask
  task automatic rd(input logic [11:0] a);
    u_host.xfer(0, a, 32'h0, q, err);
    if (u_host.stuck != 0) stop_test;
  endtask
  // a quiet pair after the burst breaks any run of idle pairs
  task automatic pairs(input logic [9:0] p, input int n);
    repeat (n) begin
      rx_pair_in <= p;
      rx_pair_valid_in <= 1;
      @(posedge clock_in);
    end
    rx_pair_in <= 10'h000;
    rx_pair_valid_in <= 1;
    @(posedge clock_in);
    rx_pair_valid_in <= 0;
    @(posedge clock_in);
  endtask
  task automatic stop_test;
    n_errors += u_host.stuck;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #2000000 n_errors++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clock_in);
    rstn_in <= 1;
    @(posedge clock_in);
    rd(rx_history_b_pkg::history_b_offset);
    chk(q[7:0], rx_history_b_pkg::history_reset);
    chk({7'h0, summary}, 8'h00);
    wr(rx_history_b_pkg::state_threshold_offset, 32'hff);
    foreach (rows[i]) begin
      if (rows[i].c) wr(rx_history_b_pkg::history_b_offset, 32'h0);
      creg <= rows[i].cr;
      cmask <= rows[i].cm;
      line_unknown_in <= rows[i].u;
      elastic_fault_in <= rows[i].e;
      pairs(rows[i].p, rows[i].n);
      {creg, cmask, line_unknown_in, elastic_fault_in} <= '0;
      rd(rx_history_b_pkg::history_b_offset);
      chk(q[7:0] & 8'hfd, rows[i].x);
    end
    wr(rx_history_b_pkg::state_threshold_offset, 32'h10);
    wr(rx_history_b_pkg::history_b_offset, 32'h0);
    rd(rx_history_b_pkg::history_b_offset);
    chk({7'h0, q[1]}, 8'h00);
    repeat (30) @(posedge clock_in);
    rd(rx_history_b_pkg::history_b_offset);
    chk({7'h0, q[1]}, 8'h01);
    wr(rx_history_b_pkg::history_b_offset, 32'hff);
    rd(rx_history_b_pkg::history_b_offset);
    chk({7'h0, q[7]}, 8'h00);
    wr(rx_history_b_pkg::mask_b_offset, 32'h80);
    chk({7'h0, summary}, 8'h00);
    wr(rx_history_b_pkg::mask_b_offset, 32'h04);
    chk({7'h0, summary}, 8'h00);
    pairs(10'h311, 1);
    chk({7'h0, summary}, 8'h01);
    wr(rx_history_b_pkg::state_threshold_offset, 32'hff);
    wr(rx_history_b_pkg::history_b_offset, 32'h0);
    wr(rx_history_b_pkg::irq_mask_offset, 32'h1);
    wr(rx_history_b_pkg::irq_status_offset, 32'h3);
    chk({7'h0, irq}, 8'h00);
    pairs(10'h311, 1);
    chk({7'h0, irq}, 8'h01);
    wr(rx_history_b_pkg::irq_mask_offset, 32'h0);
    chk({7'h0, irq}, 8'h00);
    wr(rx_history_b_pkg::control_offset, 32'h1);
    wr(rx_history_b_pkg::history_b_offset, 32'h0);
    cready <= 0;
    repeat (5) @(posedge clock_in);
    rd(rx_history_b_pkg::history_b_offset);
    chk({7'h0, q[4]}, 8'h01);
    cready <= 1;
    wr(rx_history_b_pkg::history_b_offset, 32'h0);
    cready <= 0;
    cstart <= 1;
    repeat (5) @(posedge clock_in);
    rd(rx_history_b_pkg::history_b_offset);
    chk({7'h0, q[4]}, 8'h00);
    {cready, cstart} <= 2'b10;
    wr(rx_history_b_pkg::control_offset, 32'h0);
    rd(12'hffc);
    chk({7'h0, err}, 8'h01);
    chk(q[7:0], 8'h00);
    stop_test;
  end
endmodule
